// file: rtl/lpsc_regs.vh
`ifndef LPSC_REGS_VH
`define LPSC_REGS_VH
// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define LPSC_ADDR_MODE 8'h00
`define LPSC_ADDR_CFG 8'h01
`define LPSC_ADDR_RES_LO 8'h02
`define LPSC_ADDR_RES_HI 8'h03
`define LPSC_ADDR_LTH_LO 8'h04
`define LPSC_ADDR_LTH_HI 8'h05
`define LPSC_ADDR_UTH_LO 8'h06
`define LPSC_ADDR_UTH_HI 8'h07
`define LPSC_ADDR_TEST 8'h08
// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define LPSC_RST_ZERO 8'h00
`define LPSC_RST_ONES 8'hFF
`define LPSC_RST_WORD 16'h0000
`define LPSC_MODE_MSB 7
`define LPSC_MODE_LSB 5
`define LPSC_FLAG_BIT 2
`define LPSC_PERS_MSB 1
`define LPSC_SCHEME_BIT 7
`define LPSC_MOD_BIT 6
`define LPSC_DRV_MSB 5
`define LPSC_DRV_LSB 4
`define LPSC_RESN_MSB 3
`define LPSC_RESN_LSB 2
`define LPSC_FS_MSB 1
// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define LPSC_MODE_OFF 3'h0
`define LPSC_MODE_VIS_ONCE 3'h1
`define LPSC_MODE_IR_ONCE 3'h2
`define LPSC_MODE_PROX_ONCE 3'h3
`define LPSC_MODE_RSVD 3'h4
`define LPSC_MODE_VIS_CONT 3'h5
`define LPSC_MODE_IR_CONT 3'h6
`define LPSC_MODE_PROX_CONT 3'h7
// ----------------------------------------------------------------
// serial link
// ----------------------------------------------------------------
`define LPSC_SLAVE_ADDR 7'h44
`define LPSC_BIT_LAST 3'h7
// ----------------------------------------------------------------
// timing: led modulation half period at 250 MHz
// ----------------------------------------------------------------
`define LPSC_CLK_KHZ 250000
`define LPSC_MOD_KHZ 360
`define LPSC_MOD_HALF (`LPSC_CLK_KHZ / (2 * `LPSC_MOD_KHZ))
// last count of a half period, LPSC_MOD_HALF - 1
`define LPSC_MOD_LAST 10'h15A
`define LPSC_LEN_16 17'h10000
`define LPSC_LEN_12 17'h01000
`define LPSC_LEN_8 17'h00100
`define LPSC_LEN_4 17'h00010
`define LPSC_PERS_1 5'h01
`define LPSC_PERS_4 5'h04
`define LPSC_PERS_8 5'h08
`define LPSC_PERS_16 5'h10
`endif

// file: rtl/lpsc_light_proximity_sensor_control.v
// Summary of operation
// R1: mode bits 7:5, off and single conversions
// R2: 101/110/111 continuous; 100 reserved
// R3: bit 2 flag, holds interrupt pin low
// R4: mode register transfer clears flag and pin
// R5: interrupt after m out-of-window integrations
// R6: persistence bits 1:0 give 1/4/8/16
// R7: scheme 0 proximity unsigned full n bits
// R8: scheme 1 signed n-1 bits, ambient subtracted
// R9: bit 6 selects DC or 360 kHz LED
// R10: bits 5:4 drive level passed to driver
// R11: bits 3:2 resolution 16/12/8/4 bits
// R12: integration lasts 2^n oscillator cycles
// R13: bits 1:0 full-scale code to front end
// R14: result low at 02, high at 03
// R15: result right aligned from bit 0
// R16: result updated each conversion end
// R17: lower threshold at 04/05, default zero
// R18: upper threshold at 06/07, default FF
// R19: test register at 08 reads zero
// R20: single mode powers down after conversion
// R21: mode change clears persistence counter
// R22: answer only slave address 1000100
// R23: out of window: above upper or below lower
// R24: compare 16-bit result after each integration
// R25: mode register bits 4:3 read zero
`timescale 1ns/10ps
`include "lpsc_regs.vh"
module lpsc_light_proximity_sensor_control (
  input wire clk,
  input wire reset_n,
  input wire clkEnable,
  input wire oscTick,
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe_n,
  input wire [15:0] adcCount,
  input wire [15:0] ambientCount,
  output reg adcRun,
  output reg [1:0] sensorSelect,
  output reg [1:0] fullScaleSpan,
  output reg [1:0] ledDriveLevel,
  output reg ledDrivePin,
  output reg interrupt_n
);
// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [2:0] mode_reg;
reg flag_reg;
reg [1:0] pers_reg;
reg [7:0] cfg_reg;
reg [15:0] result_reg;
reg [15:0] lowerLimitBits_reg;
reg [15:0] upperLimitBits_reg;
reg [4:0] persCnt_reg;
reg [16:0] intCnt_reg;
reg [9:0] modCnt_reg;
reg modPhase_reg;
// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg sclMeta_reg;
reg sclSync_reg;
reg sclPrev_reg;
reg sdaMeta_reg;
reg sdaSync_reg;
reg sdaPrev_reg;
reg oscMeta_reg;
reg oscSync_reg;
reg oscPrev_reg;
always @(posedge clk)
begin
  if (!reset_n)
  begin
    sclMeta_reg <= 1'b1;
    sclSync_reg <= 1'b1;
    sclPrev_reg <= 1'b1;
    sdaMeta_reg <= 1'b1;
    sdaSync_reg <= 1'b1;
    sdaPrev_reg <= 1'b1;
    oscMeta_reg <= 1'b0;
    oscSync_reg <= 1'b0;
    oscPrev_reg <= 1'b0;
  end
  else if (clkEnable)
  begin
    sclMeta_reg <= sclIn;
    sclSync_reg <= sclMeta_reg;
    sclPrev_reg <= sclSync_reg;
    sdaMeta_reg <= sdaIn;
    sdaSync_reg <= sdaMeta_reg;
    sdaPrev_reg <= sdaSync_reg;
    oscMeta_reg <= oscTick;
    oscSync_reg <= oscMeta_reg;
    oscPrev_reg <= oscSync_reg;
  end
end
wire sclRise = sclSync_reg & ~sclPrev_reg;
wire sclFall = ~sclSync_reg & sclPrev_reg;
wire startCond = sclSync_reg & sclPrev_reg & sdaPrev_reg & ~sdaSync_reg;
wire stopCond = sclSync_reg & sclPrev_reg & ~sdaPrev_reg & sdaSync_reg;
wire oscEdge = oscSync_reg & ~oscPrev_reg;
// ----------------------------------------------------------------
// serial slave
// ----------------------------------------------------------------
localparam ST_IDLE = 3'd0;
localparam ST_ADDR = 3'd1;
localparam ST_AACK = 3'd2;
localparam ST_WRX = 3'd3;
localparam ST_WACK = 3'd4;
localparam ST_RTX = 3'd5;
localparam ST_RACK = 3'd6;
reg [2:0] state_reg;
reg [2:0] bitCnt_reg;
reg [7:0] shift_reg;
reg [7:0] ptr_reg;
reg ptrSet_reg;
reg readDir_reg;
reg modeTouched_reg;
reg addrArmed_reg;
reg [7:0] rdData;
always @*
begin
  case (ptr_reg)
    `LPSC_ADDR_MODE: rdData = {mode_reg, 2'b00, flag_reg, pers_reg}; // R3 R25
    `LPSC_ADDR_CFG: rdData = cfg_reg;
    `LPSC_ADDR_RES_LO: rdData = result_reg[7:0]; // R14
    `LPSC_ADDR_RES_HI: rdData = result_reg[15:8]; // R14
    `LPSC_ADDR_LTH_LO: rdData = lowerLimitBits_reg[7:0];
    `LPSC_ADDR_LTH_HI: rdData = lowerLimitBits_reg[15:8];
    `LPSC_ADDR_UTH_LO: rdData = upperLimitBits_reg[7:0];
    `LPSC_ADDR_UTH_HI: rdData = upperLimitBits_reg[15:8];
    default: rdData = `LPSC_RST_ZERO; // R19
  endcase
end
wire wrByte = (state_reg == ST_WRX) && sclRise && (bitCnt_reg == `LPSC_BIT_LAST)
  && ptrSet_reg;
wire [7:0] wrValue = {shift_reg[6:0], sdaSync_reg};
wire endOfTransfer = stopCond || startCond;
wire modeClear = endOfTransfer && modeTouched_reg; // R4
always @(posedge clk)
begin
  if (!reset_n)
  begin
    state_reg <= ST_IDLE;
    bitCnt_reg <= 3'h0;
    shift_reg <= `LPSC_RST_ZERO;
    ptr_reg <= `LPSC_RST_ZERO;
    ptrSet_reg <= 1'b0;
    readDir_reg <= 1'b0;
    modeTouched_reg <= 1'b0;
    addrArmed_reg <= 1'b0;
    sdaOe_n <= 1'b1;
    sdaOut <= 1'b0;
  end
  else if (clkEnable)
  begin
    if (endOfTransfer)
      modeTouched_reg <= 1'b0;
    if (startCond)
    begin
      state_reg <= ST_ADDR;
      bitCnt_reg <= 3'h0;
      addrArmed_reg <= 1'b0;
      sdaOe_n <= 1'b1;
    end
    else if (stopCond)
    begin
      state_reg <= ST_IDLE;
      sdaOe_n <= 1'b1;
    end
    else
      case (state_reg)
        ST_ADDR:
          if (sclRise)
          begin
            shift_reg <= wrValue;
            bitCnt_reg <= bitCnt_reg + 3'h1;
            addrArmed_reg <= 1'b1;
          end
          // ignore the scl fall that ends the start condition
          else if (sclFall && bitCnt_reg == 3'h0 && addrArmed_reg)
          begin
            if (shift_reg[7:1] == `LPSC_SLAVE_ADDR) // R22
            begin
              readDir_reg <= shift_reg[0];
              sdaOe_n <= 1'b0;
              state_reg <= ST_AACK;
            end
            else
              state_reg <= ST_IDLE;
          end
        ST_AACK:
          if (sclFall)
          begin
            if (readDir_reg)
            begin
              shift_reg <= rdData;
              sdaOe_n <= rdData[7];
              bitCnt_reg <= 3'h1;
              state_reg <= ST_RTX;
            end
            else
            begin
              sdaOe_n <= 1'b1;
              ptrSet_reg <= 1'b0;
              bitCnt_reg <= 3'h0;
              state_reg <= ST_WRX;
            end
          end
        ST_WRX:
          if (sclRise)
          begin
            shift_reg <= wrValue;
            bitCnt_reg <= bitCnt_reg + 3'h1;
          end
          else if (sclFall && bitCnt_reg == 3'h0)
          begin
            sdaOe_n <= 1'b0;
            state_reg <= ST_WACK;
            if (!ptrSet_reg)
            begin
              ptr_reg <= shift_reg;
              ptrSet_reg <= 1'b1;
            end
            if (shift_reg == `LPSC_ADDR_MODE && !ptrSet_reg)
              modeTouched_reg <= 1'b1;
          end
        ST_WACK:
          if (sclFall)
          begin
            sdaOe_n <= 1'b1;
            state_reg <= ST_WRX;
          end
        ST_RTX:
          if (sclFall)
          begin
            if (bitCnt_reg == 3'h0)
            begin
              sdaOe_n <= 1'b1;
              state_reg <= ST_RACK;
            end
            else
            begin
              sdaOe_n <= shift_reg[~bitCnt_reg];
              bitCnt_reg <= bitCnt_reg + 3'h1;
            end
          end
        ST_RACK:
          if (sclRise)
          begin
            if (sdaSync_reg)
              state_reg <= ST_IDLE;
            else
              ptr_reg <= ptr_reg + 8'h01;
          end
          else if (sclFall)
          begin
            shift_reg <= rdData;
            sdaOe_n <= rdData[7];
            bitCnt_reg <= 3'h1;
            state_reg <= ST_RTX;
          end
        default: state_reg <= ST_IDLE;
      endcase
    if (state_reg == ST_RTX || state_reg == ST_RACK)
      modeTouched_reg <= modeTouched_reg | (ptr_reg == `LPSC_ADDR_MODE);
    if (wrByte && ptr_reg == `LPSC_ADDR_MODE)
      modeTouched_reg <= 1'b1;
  end
end
// ----------------------------------------------------------------
// register writes, conversion and interrupt
// ----------------------------------------------------------------
reg [4:0] persTarget;
reg [16:0] intLen;
reg [15:0] convValue;
always @*
begin
  case (pers_reg) // R6
    2'b00: persTarget = `LPSC_PERS_1;
    2'b01: persTarget = `LPSC_PERS_4;
    2'b10: persTarget = `LPSC_PERS_8;
    default: persTarget = `LPSC_PERS_16;
  endcase
  case (cfg_reg[`LPSC_RESN_MSB:`LPSC_RESN_LSB]) // R11 R12
    2'b00: intLen = `LPSC_LEN_16;
    2'b01: intLen = `LPSC_LEN_12;
    2'b10: intLen = `LPSC_LEN_8;
    default: intLen = `LPSC_LEN_4;
  endcase
  if (mode_reg[1:0] == 2'b11 && cfg_reg[`LPSC_SCHEME_BIT])
    convValue = (adcCount - ambientCount) >> 1; // R8
  else
    convValue = adcCount; // R7
  case (cfg_reg[`LPSC_RESN_MSB:`LPSC_RESN_LSB]) // R15
    2'b00: convValue = convValue;
    2'b01: convValue = {4'h0, convValue[11:0]};
    2'b10: convValue = {8'h00, convValue[7:0]};
    default: convValue = {12'h000, convValue[3:0]};
  endcase
end
wire running = (mode_reg != `LPSC_MODE_OFF) && (mode_reg != `LPSC_MODE_RSVD);
wire convDone = running && oscEdge && (intCnt_reg == intLen - 17'h1); // R12
wire outWindow = (convValue > upperLimitBits_reg) ||
  (convValue < lowerLimitBits_reg); // R23 R24
wire [2:0] newMode = wrValue[`LPSC_MODE_MSB:`LPSC_MODE_LSB];
wire modeWrite = wrByte && ptr_reg == `LPSC_ADDR_MODE;
always @(posedge clk)
begin
  if (!reset_n)
  begin
    mode_reg <= `LPSC_MODE_OFF;
    pers_reg <= 2'b00;
    flag_reg <= 1'b0;
    cfg_reg <= `LPSC_RST_ZERO;
    result_reg <= `LPSC_RST_WORD;
    lowerLimitBits_reg <= {`LPSC_RST_ZERO, `LPSC_RST_ZERO};
    upperLimitBits_reg <= {`LPSC_RST_ONES, `LPSC_RST_ONES};
    persCnt_reg <= 5'h00;
    intCnt_reg <= 17'h0;
  end
  else if (clkEnable)
  begin
    if (wrByte)
      case (ptr_reg)
        `LPSC_ADDR_MODE: pers_reg <= wrValue[`LPSC_PERS_MSB:0]; // R25
        `LPSC_ADDR_CFG: cfg_reg <= wrValue;
        `LPSC_ADDR_LTH_LO: lowerLimitBits_reg[7:0] <= wrValue; // R17
        `LPSC_ADDR_LTH_HI: lowerLimitBits_reg[15:8] <= wrValue; // R17
        `LPSC_ADDR_UTH_LO: upperLimitBits_reg[7:0] <= wrValue; // R18
        `LPSC_ADDR_UTH_HI: upperLimitBits_reg[15:8] <= wrValue; // R18
        default: ;
      endcase
    if (!running || modeWrite)
      intCnt_reg <= 17'h0;
    else if (oscEdge)
      intCnt_reg <= convDone ? 17'h0 : intCnt_reg + 17'h1;
    if (modeWrite)
    begin
      mode_reg <= newMode; // R1 R2
      if (newMode != mode_reg)
        persCnt_reg <= 5'h00; // R21
    end
    else if (convDone)
    begin
      result_reg <= convValue; // R16
      if (!mode_reg[2])
        mode_reg <= `LPSC_MODE_OFF; // R20
      if (!outWindow)
        persCnt_reg <= 5'h00;
      else if (persCnt_reg != persTarget)
        persCnt_reg <= persCnt_reg + 5'h01; // R5
    end
    if (convDone && outWindow && persCnt_reg + 5'h01 >= persTarget)
      flag_reg <= 1'b1; // R5
    else if (modeClear)
      flag_reg <= 1'b0; // R4
  end
end
// ----------------------------------------------------------------
// front end controls and led modulation
// ----------------------------------------------------------------
wire proxActive = running && mode_reg[1:0] == 2'b11;
always @(posedge clk)
begin
  if (!reset_n)
  begin
    modCnt_reg <= 10'h0;
    modPhase_reg <= 1'b0;
    adcRun <= 1'b0;
    sensorSelect <= 2'b00;
    fullScaleSpan <= 2'b00;
    ledDriveLevel <= 2'b00;
    ledDrivePin <= 1'b0;
    interrupt_n <= 1'b1;
  end
  else if (clkEnable)
  begin
    if (modCnt_reg == `LPSC_MOD_LAST)
    begin
      modCnt_reg <= 10'h0;
      modPhase_reg <= ~modPhase_reg;
    end
    else
      modCnt_reg <= modCnt_reg + 10'h1;
    adcRun <= running;
    sensorSelect <= mode_reg[1:0];
    fullScaleSpan <= cfg_reg[`LPSC_FS_MSB:0]; // R13
    ledDriveLevel <= cfg_reg[`LPSC_DRV_MSB:`LPSC_DRV_LSB]; // R10
    ledDrivePin <= proxActive &&
      (!cfg_reg[`LPSC_MOD_BIT] || modPhase_reg); // R9
    interrupt_n <= ~flag_reg; // R3
  end
end
endmodule // lpsc_light_proximity_sensor_control

// file: dv/lpsc_sensor_asserts.sv
`timescale 1ns/10ps
`include "lpsc_regs.vh"
module lpsc_sensor_asserts (
  input wire clk,
  input wire reset_n,
  input wire sclIn,
  input wire sdaOe_n,
  input wire adcRun,
  input wire [1:0] sensorSelect,
  input wire ledDrivePin,
  input wire interrupt_n
);
  // ------------------------------------------------------------
  // led high-phase length
  // ------------------------------------------------------------
  reg [15:0] hiCnt_reg;
  wire [15:0] hiCnt_next = ledDrivePin ? hiCnt_reg + 16'h0001 : 16'h0000;
  always @(posedge clk)
    hiCnt_reg <= reset_n ? hiCnt_next : 16'h0000;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_run_select: assert property (adcRun |-> sensorSelect != 2'h0)
    else $error("conversion with no sensor");
  chk_led_off: assert property (
    (!adcRun || sensorSelect != 2'h3) [*2] |-> !ledDrivePin)
    else $error("led on outside proximity");
  chk_led_half: assert property (
    $fell(ledDrivePin) && adcRun |-> hiCnt_reg <= `LPSC_MOD_HALF + 3)
    else $error("led half period too long");
  chk_int_cause: assert property (
    $fell(interrupt_n) |-> $past(adcRun, 2))
    else $error("interrupt without conversion");
  chk_int_clear: assert property (
    $rose(interrupt_n) |-> sclIn && $past(sclIn, 4))
    else $error("interrupt released outside stop or start");
  chk_int_hold: assert property (
    !interrupt_n && !sclIn |=> !interrupt_n)
    else $error("interrupt released while clock low");
  chk_sda_edge: assert property ($changed(sdaOe_n) |-> !sclIn)
    else $error("sda changed while clock high");
  chk_ack_stand: assert property (
    $fell(sdaOe_n) |=> !sdaOe_n [*8])
    else $error("sda pull too short");
  cov_conv_done: cover property ($fell(adcRun));
  cov_irq_set: cover property ($fell(interrupt_n));
  cov_irq_clear: cover property ($rose(interrupt_n));
  cov_led_mod: cover property ($fell(ledDrivePin) && adcRun);
endmodule // lpsc_sensor_asserts
bind lpsc_light_proximity_sensor_control lpsc_sensor_asserts u_chk (
  .clk(clk), .reset_n(reset_n), .sclIn(sclIn), .sdaOe_n(sdaOe_n),
  .adcRun(adcRun), .sensorSelect(sensorSelect),
  .ledDrivePin(ledDrivePin), .interrupt_n(interrupt_n)
);

// file: dv/lpsc_i2c_host.sv
`timescale 1ns/10ps
`include "lpsc_regs.vh"
module lpsc_i2c_host (
  input wire clk,
  input wire sdaOe_n,
  output reg scl,
  output wire sda
);
  // ------------------------------------------------------------
  // bit-level master, sda pulled up when released
  // ------------------------------------------------------------
  reg sdaDrv = 1'b1;
  assign sda = sdaDrv & sdaOe_n;
  initial scl = 1'b1;
  task hp;
    repeat (10) @(negedge clk);
  endtask
  task bitx(input b, output r);
    sdaDrv = b;
    hp;
    scl = 1'b1;
    hp;
    r = sda;
    scl = 1'b0;
  endtask
  task xbyte(input [7:0] d, input mAck, output [7:0] q, output nak);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
      bitx(d[i], q[i]);
    bitx(mAck, nak);
  endtask
  task start;
    sdaDrv = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sdaDrv = 1'b0;
    hp;
    scl = 1'b0;
  endtask
  task stop;
    sdaDrv = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sdaDrv = 1'b1;
    hp;
  endtask
  task wr(input [6:0] sa, input [7:0] a, input [7:0] d, output ok);
    reg [7:0] q;
    reg n0, n1, n2;
    start;
    xbyte({sa, 1'b0}, 1'b1, q, n0);
    xbyte(a, 1'b1, q, n1);
    xbyte(d, 1'b1, q, n2);
    stop;
    ok = !(n0 | n1 | n2);
  endtask
  task rd(input [7:0] a, output [7:0] d);
    reg [7:0] q;
    reg n;
    start;
    xbyte({`LPSC_SLAVE_ADDR, 1'b0}, 1'b1, q, n);
    xbyte(a, 1'b1, q, n);
    start;
    xbyte({`LPSC_SLAVE_ADDR, 1'b1}, 1'b1, q, n);
    xbyte(8'hFF, 1'b1, d, n);
    stop;
  endtask
endmodule // lpsc_i2c_host

// file: dv/lpsc_tb.sv
`timescale 1ns/10ps
`include "lpsc_regs.vh"
`define CHECK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module testbench;
  localparam int TICK = 40;
  localparam int CONV = 32 * TICK;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg oscTick = 1'b0;
  reg clkEnable = 1'b1;
  reg [15:0] adcCount = 16'h0000;
  reg [15:0] ambientCount = 16'h0000;
  wire sclIn, sdaIn, sdaOe_n, adcRun, ledDrivePin, interrupt_n;
  wire [1:0] sensorSelect, fullScaleSpan, ledDriveLevel;
  int err_total = 0;
  int n_checks = 0;
  reg [7:0] rdData;
  reg ack;
  always #2 clk = ~clk;
  always
  begin
    repeat (TICK) @(negedge clk);
    oscTick <= ~oscTick;
  end
  lpsc_light_proximity_sensor_control dut (
    .clk(clk), .reset_n(reset_n), .clkEnable(clkEnable), .oscTick(oscTick),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(), .sdaOe_n(sdaOe_n),
    .adcCount(adcCount), .ambientCount(ambientCount), .adcRun(adcRun),
    .sensorSelect(sensorSelect), .fullScaleSpan(fullScaleSpan),
    .ledDriveLevel(ledDriveLevel), .ledDrivePin(ledDrivePin),
    .interrupt_n(interrupt_n)
  );
  lpsc_i2c_host host (
    .clk(clk), .sdaOe_n(sdaOe_n), .scl(sclIn), .sda(sdaIn)
  );
  // ------------------------------------------------------------
  // access helpers
  // ------------------------------------------------------------
  task wr(input [7:0] a, input [7:0] d);
    host.wr(`LPSC_SLAVE_ADDR, a, d, ack);
    `CHECK(ack, 1'b1)
  endtask
  task rdChk(input [7:0] a, input [7:0] e);
    host.rd(a, rdData);
    `CHECK(rdData, e)
  endtask
  task run_conv(output int cyc, output int falls);
    reg prevLed;
    cyc = 0;
    falls = 0;
    prevLed = ledDrivePin;
    while (adcRun && cyc < 3 * CONV)
    begin
      @(negedge clk);
      cyc++;
      if (prevLed && !ledDrivePin && adcRun)
        falls++;
      prevLed = ledDrivePin;
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_regs;
    rdChk(`LPSC_ADDR_LTH_LO, 8'h00);
    rdChk(`LPSC_ADDR_LTH_HI, 8'h00);
    rdChk(`LPSC_ADDR_UTH_LO, 8'hFF);
    rdChk(`LPSC_ADDR_UTH_HI, 8'hFF);
    rdChk(`LPSC_ADDR_TEST, 8'h00);
    wr(`LPSC_ADDR_RES_LO, 8'hA5);
    rdChk(`LPSC_ADDR_RES_LO, 8'h00);
    host.wr(7'h45, `LPSC_ADDR_LTH_LO, 8'h12, ack);
    `CHECK(ack, 1'b0)
    rdChk(`LPSC_ADDR_LTH_LO, 8'h00);
  endtask
  task t_config;
    wr(`LPSC_ADDR_CFG, 8'h2D);
    `CHECK(ledDriveLevel, 2'h2)
    `CHECK(fullScaleSpan, 2'h1)
    rdChk(`LPSC_ADDR_CFG, 8'h2D);
    wr(`LPSC_ADDR_MODE, 8'h1F);
    rdChk(`LPSC_ADDR_MODE, 8'h03);
  endtask
  task t_single;
    int cyc;
    int falls;
    adcCount = 16'h1234;
    wr(`LPSC_ADDR_MODE, 8'h20);
    `CHECK(sensorSelect, 2'h1)
    // freeze a whole number of oscillator periods
    clkEnable = 1'b0;
    repeat (2 * CONV) @(negedge clk);
    `CHECK(adcRun, 1'b1)
    clkEnable = 1'b1;
    run_conv(cyc, falls);
    `CHECK(adcRun, 1'b0)
    `CHECK(cyc >= 28 * TICK && cyc <= 33 * TICK, 1'b1)
    rdChk(`LPSC_ADDR_RES_LO, 8'h04);
    rdChk(`LPSC_ADDR_RES_HI, 8'h00);
    rdChk(`LPSC_ADDR_MODE, 8'h00);
  endtask
  task t_prox;
    int cyc;
    int falls;
    int k;
    adcCount = 16'h0019;
    ambientCount = 16'h0005;
    for (k = 0; k < 4; k++)
    begin
      wr(`LPSC_ADDR_CFG, {k[1], k[0], 6'h0F});
      wr(`LPSC_ADDR_MODE, 8'h60);
      `CHECK(sensorSelect, 2'h3)
      run_conv(cyc, falls);
      `CHECK(falls > 0, k[0])
      rdChk(`LPSC_ADDR_RES_LO, k[1] ? 8'h0A : 8'h09);
    end
  endtask
  task t_irq;
    adcCount = 16'h0008;
    wr(`LPSC_ADDR_UTH_LO, 8'h05);
    wr(`LPSC_ADDR_UTH_HI, 8'h00);
    wr(`LPSC_ADDR_MODE, 8'hA1);
    repeat (3 * CONV + CONV / 2) @(negedge clk);
    `CHECK(interrupt_n, 1'b1)
    repeat (CONV) @(negedge clk);
    `CHECK(interrupt_n, 1'b0)
    wr(`LPSC_ADDR_MODE, 8'h00);
    `CHECK(interrupt_n, 1'b1)
    wr(`LPSC_ADDR_LTH_LO, 8'h03);
    adcCount = 16'h0004;
    wr(`LPSC_ADDR_MODE, 8'hA0);
    repeat (2 * CONV) @(negedge clk);
    `CHECK(interrupt_n, 1'b1)
    adcCount = 16'h0001;
    repeat (2 * CONV) @(negedge clk);
    `CHECK(interrupt_n, 1'b0)
    // two out-of-window results, then a mode change
    wr(`LPSC_ADDR_MODE, 8'hC1);
    `CHECK(interrupt_n, 1'b1)
    repeat (2 * CONV + CONV / 4) @(negedge clk);
    wr(`LPSC_ADDR_MODE, 8'hA1);
    repeat (3 * CONV + CONV / 2) @(negedge clk);
    `CHECK(interrupt_n, 1'b1)
    repeat (CONV) @(negedge clk);
    `CHECK(interrupt_n, 1'b0)
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs;
    t_config;
    t_single;
    t_prox;
    t_irq;
    final_report;
  end
  // about 1.7 times the expected run length
  initial
  begin
    repeat (90000) @(negedge clk);
    err_total++;
    final_report;
  end
endmodule // testbench
